// ===== hdl/module_mgmt_ctrl_timing.sv
module module_mgmt_ctrl_timing
	import mgmt_pkg::*;
#(
	parameter int unsigned INIT_CYCLES = INIT_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        serial_clk,
	input  wire logic        serial_stop,
	input  wire logic        serial_read,
	input  wire logic [7:0]  serial_addr,
	input  wire logic [7:0]  serial_wdata,
	output logic             serial_answer_en,
	input  wire logic        module_reset_low_pin,
	input  wire logic        module_select_low_pin,
	input  wire logic        low_power_request_pin,
	input  wire logic [3:0]  rx_los_cond,
	input  wire logic [3:0]  tx_fault_cond,
	output logic             interrupt_low_pin,
	output logic             module_present_low_pin,
	output logic             low_power_out,
	output logic             data_not_ready
);
	localparam int RW = $clog2(RST_MIN_CYC + 1);
	localparam logic [RW-1:0] RST_MIN = RW'(RST_MIN_CYC);

	init_state_e       state_ff;
	init_state_e       nxt_state;
	logic [31:0]       init_cnt_ff;
	logic [RW-1:0]     rst_cnt_ff;
	logic              rst_hit_ff;
	logic [10:0]       pins_s;
	logic              rst_low_s;
	logic              sel_low_s;
	logic              lp_s;
	logic [3:0]        los_s;
	logic [3:0]        fault_s;
	logic              req_s;
	logic              ack_ff;
	logic              cap_read;
	logic [7:0]        cap_addr;
	logic [7:0]        cap_wdata;
	logic              req_tgl;
	logic              ev;
	logic              ev_rd;
	logic              ev_wr;
	logic [2*LANES-1:0] flag_ff;
	logic [2*LANES-1:0] mask_ff;
	logic              init_flag_ff;
	logic              pdown_ff;
	logic              low_power_ff;
	logic              answer_ff;
	logic              int_low_ff;
	logic              pending;
	logic [31:0]       prdata_ff;
	logic              apb_wr;

	// Word-aligned decode of the four APB registers
	function automatic logic mapped(input logic [11:0] a);
		return a == A_STATUS || a == A_FLAGS || a == A_MASK || a == A_CTRL;
	endfunction

	// Outside-pclk inputs; active-low pins enter inverted so reset leaves them idle
	sync2 #(.W(11)) pin_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.d     ({~module_reset_low_pin, ~module_select_low_pin, low_power_request_pin,
			rx_los_cond, tx_fault_cond}),
		.q     (pins_s)
	);
	assign rst_low_s = !pins_s[10];
	assign sel_low_s = !pins_s[9];
	assign lp_s      = pins_s[8];
	assign los_s     = pins_s[7:4];
	assign fault_s   = pins_s[3:0];

	// Serial-clock domain front end
	link_capture link (
		.serial_clk   (serial_clk),
		.presetn      (presetn),
		.serial_stop  (serial_stop),
		.serial_read  (serial_read),
		.serial_addr  (serial_addr),
		.serial_wdata (serial_wdata),
		.ack_tgl      (ack_ff),
		.req_tgl      (req_tgl),
		.cap_read     (cap_read),
		.cap_addr     (cap_addr),
		.cap_wdata    (cap_wdata)
	);

	sync2 #(.W(1)) req_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.d     (req_tgl),
		.q     (req_s)
	);

	// Answer permission back into the serial domain
	sync2 #(.W(1)) ans_sync (
		.clk   (serial_clk),
		.rst_n (presetn),
		.d     (answer_ff),
		.q     (serial_answer_en)
	);

	// New transfer seen; captured words are stable until ack returns
	assign ev    = req_s != ack_ff;
	assign ev_rd = ev && cap_read;
	assign ev_wr = ev && !cap_read;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= req_s;
		end
	end

	// Reset pulse filter: only a low held past the minimum counts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_cnt_ff <= '0;
			rst_hit_ff <= 1'b0;
		end else if (rst_low_s) begin
			rst_cnt_ff <= '0;
			rst_hit_ff <= 1'b0;
		end else begin
			if (rst_cnt_ff != RST_MIN) begin
				rst_cnt_ff <= rst_cnt_ff + RW'(1);
			end
			rst_hit_ff <= rst_cnt_ff == RST_MIN;
		end
	end

	// Init sequencing after power-on or a module reset release
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			INIT_HOLD: begin
				if (!rst_hit_ff) begin
					nxt_state = INIT_WAIT;
				end
			end
			INIT_WAIT: begin
				if (rst_hit_ff) begin
					nxt_state = INIT_HOLD;
				end else if (init_cnt_ff >= INIT_CYCLES - 32'd1) begin
					nxt_state = INIT_READY;
				end
			end
			INIT_READY: begin
				if (rst_hit_ff) begin
					nxt_state = INIT_HOLD;
				end
			end
			default: nxt_state = INIT_HOLD;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= INIT_WAIT;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Counter restarts whenever the wait is entered anew
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_cnt_ff <= 32'h0000_0000;
		end else if (state_ff != INIT_WAIT) begin
			init_cnt_ff <= 32'h0000_0000;
		end else begin
			init_cnt_ff <= init_cnt_ff + 32'h0000_0001;
		end
	end

	assign data_not_ready = state_ff != INIT_READY;

	// Init interrupt flag; set wins over the status-byte read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_flag_ff <= 1'b0;
		end else if (state_ff == INIT_WAIT && nxt_state == INIT_READY) begin
			init_flag_ff <= 1'b1;
		end else if (state_ff == INIT_HOLD || (ev_rd && cap_addr == SB_STATUS)) begin
			init_flag_ff <= 1'b0;
		end
	end

	// Sticky flags: clear on read, live condition re-sets in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_ff <= '0;
		end else if (state_ff == INIT_HOLD) begin
			flag_ff <= '0;
		end else begin
			flag_ff[3:0] <= ((ev_rd && cap_addr == SB_FLAG_LOS) ? 4'h0 : flag_ff[3:0])
				| los_s;
			flag_ff[7:4] <= ((ev_rd && cap_addr == SB_FLAG_FAULT) ? 4'h0 : flag_ff[7:4])
				| fault_s;
		end
	end

	assign apb_wr = psel && penable && pwrite;

	// Masks from APB or serial writes; the serial write wins a tie
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_ff <= MASK_RST;
		end else if (state_ff == INIT_HOLD) begin
			mask_ff <= MASK_RST;
		end else if (ev_wr && cap_addr == SB_MASK_LOS) begin
			mask_ff[3:0] <= cap_wdata[3:0];
		end else if (ev_wr && cap_addr == SB_MASK_FAULT) begin
			mask_ff[7:4] <= cap_wdata[3:0];
		end else if (apb_wr && paddr == A_MASK) begin
			mask_ff <= pwdata[2*LANES-1:0];
		end
	end

	// Power-down override bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pdown_ff <= PDOWN_RST;
		end else if (state_ff == INIT_HOLD) begin
			pdown_ff <= PDOWN_RST;
		end else if (ev_wr && cap_addr == SB_CTRL) begin
			pdown_ff <= cap_wdata[PDOWN_BIT];
		end else if (apb_wr && paddr == A_CTRL) begin
			pdown_ff <= pwdata[CTRL_PDOWN];
		end
	end

	// Power level follows the synchronised pin or the override a cycle later, far inside the bound
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_power_ff <= 1'b0;
		end else begin
			low_power_ff <= lp_s || pdown_ff;
		end
	end

	assign low_power_out = low_power_ff;

	// Answer only when ready, selected and not held in reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			answer_ff <= 1'b0;
		end else begin
			answer_ff <= state_ff == INIT_READY && !sel_low_s;
		end
	end

	// Unmasked flags hold the interrupt low
	assign pending = |(flag_ff & ~mask_ff) || init_flag_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_low_ff <= 1'b1;
		end else begin
			int_low_ff <= !pending;
		end
	end

	assign interrupt_low_pin      = int_low_ff;
	assign module_present_low_pin = 1'b0;

	// Read data registered in the setup phase; zero-wait access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0000_0000;
		end else if (psel && !penable) begin
			prdata_ff <= 32'h0000_0000;
			if (paddr == A_STATUS) begin
				prdata_ff[ST_DNR]       <= data_not_ready;
				prdata_ff[ST_READY]     <= state_ff == INIT_READY;
				prdata_ff[ST_LOWPWR]    <= low_power_ff;
				prdata_ff[ST_ANSWER]    <= answer_ff;
				prdata_ff[ST_INIT_FLAG] <= init_flag_ff;
			end else if (paddr == A_FLAGS) begin
				prdata_ff[2*LANES-1:0] <= flag_ff;
			end else if (paddr == A_MASK) begin
				prdata_ff[2*LANES-1:0] <= mask_ff;
			end else if (paddr == A_CTRL) begin
				prdata_ff[CTRL_PDOWN] <= pdown_ff;
			end
		end
	end

	assign prdata  = prdata_ff;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped(paddr);

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	not_ready_a: assert property (state_ff != INIT_READY |=> !answer_ff)
		else $error("answer enabled before ready");
	dnr_ready_a: assert property ($rose(state_ff == INIT_READY) |-> !data_not_ready ##1 !int_low_ff)
		else $error("ready without dnr clear and interrupt");
	lp_follow_a: assert property (lp_s |=> low_power_ff)
		else $error("low power pin not followed");
	pdown_on_a: assert property (pdown_ff |=> low_power_ff)
		else $error("power-down not entered");
	pdown_off_a: assert property ($fell(pdown_ff) && !lp_s |=> !low_power_ff)
		else $error("power-down not left");
	los_set_a: assert property (state_ff != INIT_HOLD && los_s[0] |=> flag_ff[0] ##1 (!int_low_ff || $past(mask_ff[0])))
		else $error("loss flag or interrupt missing");
	read_clr_a: assert property (ev_rd && cap_addr == SB_FLAG_LOS && los_s == 4'h0
		|=> flag_ff[3:0] == 4'h0)
		else $error("flag not cleared by read");
	mask_hold_a: assert property ((flag_ff & ~mask_ff) == '0 && !init_flag_ff |=> int_low_ff)
		else $error("masked flag drives interrupt");
	desel_a: assert property (sel_low_s |=> !answer_ff)
		else $error("answer while deselected");
	rst_hold_a: assert property (rst_hit_ff |=> state_ff == INIT_HOLD)
		else $error("qualified reset not taken");

	ready_c: cover property ($rose(state_ff == INIT_READY));
	flag_read_c: cover property (ev_rd && cap_addr == SB_FLAG_FAULT && flag_ff[7:4] != 4'h0);
	pdown_c: cover property (ev_wr && cap_addr == SB_CTRL ##1 pdown_ff);
	reset_c: cover property ($fell(rst_hit_ff) ##1 state_ff == INIT_WAIT);
endmodule

// ===== hdl/mgmt_pkg.sv
package mgmt_pkg;
	// Clock rate and documented times
	localparam int CLK_MHZ      = 100;
	localparam int T_INIT_MS    = 2000;
	localparam int T_RST_MIN_US = 2;
	localparam int INIT_CYC     = T_INIT_MS * 1000 * CLK_MHZ;
	localparam int RST_MIN_CYC  = T_RST_MIN_US * CLK_MHZ;
	localparam int LANES        = 4;

	// Serial-bus byte addresses and bits
	localparam logic [7:0] SB_STATUS     = 8'h02;
	localparam logic [7:0] SB_FLAG_LOS   = 8'h03;
	localparam logic [7:0] SB_FLAG_FAULT = 8'h04;
	localparam logic [7:0] SB_CTRL       = 8'h5d;
	localparam logic [7:0] SB_MASK_LOS   = 8'h64;
	localparam logic [7:0] SB_MASK_FAULT = 8'h65;
	localparam int         PDOWN_BIT     = 1;

	// APB word map
	localparam logic [11:0] A_STATUS = 12'h000;
	localparam logic [11:0] A_FLAGS  = 12'h004;
	localparam logic [11:0] A_MASK   = 12'h008;
	localparam logic [11:0] A_CTRL   = 12'h00c;

	// Status and control word fields
	localparam int ST_DNR       = 0;
	localparam int ST_READY     = 1;
	localparam int ST_LOWPWR    = 2;
	localparam int ST_ANSWER    = 3;
	localparam int ST_INIT_FLAG = 4;
	localparam int CTRL_PDOWN   = 0;

	// Reset values
	localparam logic [2*LANES-1:0] MASK_RST  = 8'h00;
	localparam logic               PDOWN_RST = 1'b0;

	typedef enum logic [1:0] {
		INIT_HOLD  = 2'b00,
		INIT_WAIT  = 2'b01,
		INIT_READY = 2'b10
	} init_state_e;
endpackage

// ===== hdl/sync2.sv
// Two-flop level synchroniser
module sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] q_ff;

	// First stage feeds only the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= '0;
			q_ff    <= '0;
		end else begin
			meta_ff <= d;
			q_ff    <= meta_ff;
		end
	end

	assign q = q_ff;
endmodule

// ===== hdl/link_capture.sv
// Serial-clock side: catches each transfer that finishes while not busy and hands it over
module link_capture (
	input  wire logic       serial_clk,
	input  wire logic       presetn,
	input  wire logic       serial_stop,
	input  wire logic       serial_read,
	input  wire logic [7:0] serial_addr,
	input  wire logic [7:0] serial_wdata,
	input  wire logic       ack_tgl,
	output logic            req_tgl,
	output logic            cap_read,
	output logic [7:0]      cap_addr,
	output logic [7:0]      cap_wdata
);
	logic       ack_s;
	logic       req_ff;
	logic       read_ff;
	logic [7:0] addr_ff;
	logic [7:0] wdata_ff;
	logic       busy;

	sync2 #(.W(1)) ack_sync (
		.clk   (serial_clk),
		.rst_n (presetn),
		.d     (ack_tgl),
		.q     (ack_s)
	);

	// Words stay frozen until the fast side acks
	assign busy = req_ff != ack_s;

	// A stop while busy is dropped; transfers are far apart in practice
	always_ff @(posedge serial_clk or negedge presetn) begin
		if (!presetn) begin
			req_ff   <= 1'b0;
			read_ff  <= 1'b0;
			addr_ff  <= 8'h00;
			wdata_ff <= 8'h00;
		end else if (serial_stop && !busy) begin
			req_ff   <= ~req_ff;
			read_ff  <= serial_read;
			addr_ff  <= serial_addr;
			wdata_ff <= serial_wdata;
		end
	end

	assign req_tgl   = req_ff;
	assign cap_read  = read_ff;
	assign cap_addr  = addr_ff;
	assign cap_wdata = wdata_ff;
endmodule

// ===== verification/serial_host.sv
// Host side of the 2-wire bus: clocks only during a transfer
module serial_host (
	output logic       serial_clk,
	output logic       serial_stop,
	output logic       serial_read,
	output logic [7:0] serial_addr,
	output logic [7:0] serial_wdata
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle state, clock parked low
	initial begin
		serial_clk = 1'b0;
		serial_stop = 1'b0;
		serial_read = 1'b0;
		serial_addr = 8'h00;
		serial_wdata = 8'h00;
	end

	// One transfer; trailing cycles let the hand-back finish before the next stop
	task automatic xfer(input logic rd, input logic [7:0] a, input logic [7:0] d);
		#37; // Keeps the link edges off the system clock phase
		serial_read = rd;
		serial_addr = a;
		serial_wdata = d;
		serial_stop = 1'b1;
		#80 serial_clk = 1'b1;
		#80 serial_clk = 1'b0;
		// Released fields show the inverse, never the stale value
		serial_stop = 1'b0;
		serial_read = ~rd;
		serial_addr = ~a;
		serial_wdata = ~d;
		repeat (6) begin
			#80 serial_clk = 1'b1;
			#80 serial_clk = 1'b0;
		end
	endtask
endmodule

// ===== verification/tb_top.sv
module tb_top
	import mgmt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int INIT_SIM = 50; // Shortened start-up count

	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        serial_clk, serial_stop, serial_read, serial_answer_en;
	logic [7:0]  serial_addr, serial_wdata;
	logic        module_reset_low_pin, module_select_low_pin, low_power_request_pin;
	logic [3:0]  rx_los_cond, tx_fault_cond;
	logic        interrupt_low_pin, module_present_low_pin, low_power_out, data_not_ready;
	int          err_total, tests_run;

	module_mgmt_ctrl_timing #(.INIT_CYCLES(INIT_SIM)) uut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.serial_clk(serial_clk), .serial_stop(serial_stop), .serial_read(serial_read),
		.serial_addr(serial_addr), .serial_wdata(serial_wdata), .serial_answer_en(serial_answer_en),
		.module_reset_low_pin(module_reset_low_pin), .module_select_low_pin(module_select_low_pin),
		.low_power_request_pin(low_power_request_pin), .rx_los_cond(rx_los_cond),
		.tx_fault_cond(tx_fault_cond), .interrupt_low_pin(interrupt_low_pin),
		.module_present_low_pin(module_present_low_pin), .low_power_out(low_power_out),
		.data_not_ready(data_not_ready)
	);

	serial_host host (
		.serial_clk(serial_clk), .serial_stop(serial_stop), .serial_read(serial_read),
		.serial_addr(serial_addr), .serial_wdata(serial_wdata)
	);

	// System clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Lands a bit past the edge so register outputs have settled
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	// APB master: setup, then access held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Watchdog well beyond the expected run
	initial begin
		#200000;
		err_total++;
		give_verdict();
	end

	// Main sequence
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{rx_los_cond, tx_fault_cond, low_power_request_pin} = '0;
		module_reset_low_pin = 1'b1; // Host holds select high until it addresses the module
		module_select_low_pin = 1'b1;
		err_total = 0;
		tests_run = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		wait_cyc(1);
		check("dnr_rst", data_not_ready, 1);
		check("int_rst", interrupt_low_pin, 1);
		check("present", module_present_low_pin, 0);
		apb(1'b0, A_MASK, 0, rd, er);
		check("mask_rst", rd, 32'(MASK_RST));
		apb(1'b0, A_CTRL, 0, rd, er);
		check("ctrl_rst", rd, 32'(PDOWN_RST));
		apb(1'b0, 12'h040, 0, rd, er);
		check("unmapped_err", er, 1);
		check("unmapped_rd", rd, 0);
		wait_cyc(INIT_SIM + 10);
		check("dnr_init", data_not_ready, 0);
		check("int_init", interrupt_low_pin, 0);
		apb(1'b0, A_STATUS, 0, rd, er);
		check("status", rd & 32'h1f, 32'h12);
		// Selection, then reading byte 2 releases the start-up interrupt
		@(posedge pclk) module_select_low_pin <= 1'b0;
		wait_cyc(10);
		host.xfer(1'b1, SB_STATUS, 8'h00);
		check("answer_on", serial_answer_en, 1);
		check("int_init_clr", interrupt_low_pin, 1);
		// Loss of signal is sticky until read
		@(posedge pclk) rx_los_cond <= 4'h2;
		wait_cyc(10);
		check("int_los", interrupt_low_pin, 0);
		apb(1'b0, A_FLAGS, 0, rd, er);
		check("flag_los", rd, 32'h2);
		@(posedge pclk) rx_los_cond <= 4'h0;
		wait_cyc(10);
		check("int_sticky", interrupt_low_pin, 0);
		host.xfer(1'b1, SB_FLAG_LOS, 8'h00);
		check("int_los_clr", interrupt_low_pin, 1);
		// Fault masked over the link, then unmasked
		host.xfer(1'b0, SB_MASK_FAULT, 8'h01);
		apb(1'b0, A_MASK, 0, rd, er);
		check("mask_fault", rd, 32'h10);
		@(posedge pclk) tx_fault_cond <= 4'h1;
		wait_cyc(10);
		check("int_masked", interrupt_low_pin, 1);
		apb(1'b0, A_FLAGS, 0, rd, er);
		check("flag_fault", rd, 32'h10);
		host.xfer(1'b0, SB_MASK_FAULT, 8'h00);
		check("int_unmask", interrupt_low_pin, 0);
		@(posedge pclk) tx_fault_cond <= 4'h0;
		host.xfer(1'b1, SB_FLAG_FAULT, 8'h00);
		check("int_fault_clr", interrupt_low_pin, 1);
		// Mask written over APB
		apb(1'b1, A_MASK, 32'h0f, rd, er);
		apb(1'b0, A_MASK, 0, rd, er);
		check("mask_apb", rd, 32'h0f);
		@(posedge pclk) rx_los_cond <= 4'hf;
		wait_cyc(10);
		check("int_apb_mask", interrupt_low_pin, 1);
		apb(1'b1, A_MASK, 32'h00, rd, er);
		wait_cyc(10);
		check("int_apb_unmask", interrupt_low_pin, 0);
		@(posedge pclk) rx_los_cond <= 4'h0;
		host.xfer(1'b1, SB_FLAG_LOS, 8'h00);
		check("int_clr2", interrupt_low_pin, 1);
		// Low power by pin and by override bit
		@(posedge pclk) low_power_request_pin <= 1'b1;
		wait_cyc(10);
		check("lp_pin", low_power_out, 1);
		@(posedge pclk) low_power_request_pin <= 1'b0;
		wait_cyc(10);
		check("lp_pin_off", low_power_out, 0);
		host.xfer(1'b0, SB_CTRL, 8'(1 << PDOWN_BIT));
		check("pdown_on", low_power_out, 1);
		apb(1'b0, A_CTRL, 0, rd, er);
		check("ctrl_pdown", rd, 32'h1);
		host.xfer(1'b0, SB_CTRL, 8'h00);
		check("pdown_off", low_power_out, 0);
		// Override bit written over APB as well
		apb(1'b1, A_CTRL, 32'h1, rd, er);
		wait_cyc(2);
		check("pdown_apb_on", low_power_out, 1);
		apb(1'b1, A_CTRL, 32'h0, rd, er);
		wait_cyc(2);
		check("pdown_apb_off", low_power_out, 0);
		// Deselection stops answers
		@(posedge pclk) module_select_low_pin <= 1'b1;
		wait_cyc(10);
		host.xfer(1'b1, 8'h00, 8'h00);
		check("answer_off", serial_answer_en, 0);
		// A short low is ignored, a long one restarts start-up
		@(posedge pclk) module_reset_low_pin <= 1'b0;
		wait_cyc(RST_MIN_CYC / 4);
		@(posedge pclk) module_reset_low_pin <= 1'b1;
		wait_cyc(10);
		check("rst_short", data_not_ready, 0);
		@(posedge pclk) module_reset_low_pin <= 1'b0;
		wait_cyc(RST_MIN_CYC + 20);
		check("rst_long", data_not_ready, 1);
		@(posedge pclk) module_reset_low_pin <= 1'b1;
		wait_cyc(INIT_SIM + 10);
		check("rst_ready", data_not_ready, 0);
		check("rst_int", interrupt_low_pin, 0);
		give_verdict();
	end
endmodule
